// file: pkg/ppa_pkg.sv
// constants and types for the port and bus pin allocation block
package ppa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [7:0] PPA_IDX_DIR  = 8'h16;
  localparam logic [7:0] PPA_IDX_CFG  = 8'h17;
  localparam logic [7:0] PPA_IDX_REL  = 8'h18;
  localparam logic [7:0] PPA_IDX_STAT = 8'h19;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] PPA_DIR_RESET = 8'hff;
  localparam logic [3:0] PPA_CFG_RESET = 4'h8;
  localparam logic [5:0] PPA_REL_RESET = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // bus configuration fields
  localparam int PPA_CFG_MUX   = 0;
  localparam int PPA_CFG_W16   = 1;
  localparam int PPA_CFG_EXTA  = 2;
  localparam int PPA_CFG_SCHIP = 3;

  // function release fields
  localparam int PPA_REL_UADDR = 0;
  localparam int PPA_REL_WRL   = 1;
  localparam int PPA_REL_WRH   = 2;
  localparam int PPA_REL_HOLD  = 3;
  localparam int PPA_REL_RDY   = 4;
  localparam int PPA_REL_CLK   = 5;

  // port 5 pin positions
  localparam int PPA_P5_ALE = 7;
  localparam int PPA_P5_WRL = 5;
  localparam int PPA_P5_WRH = 4;
  localparam int PPA_P5_HRQ = 3;
  localparam int PPA_P5_HAK = 2;
  localparam int PPA_P5_RDY = 1;
  localparam int PPA_P5_CLK = 0;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite codes
  localparam int         PPA_HTRANS_ACT = 1;
  localparam logic [2:0] PPA_HSIZE_WORD = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // port 1 pin function
  typedef enum logic [1:0] {
    PPA_P1_PORT,
    PPA_P1_DATA,
    PPA_P1_ADDR,
    PPA_P1_ADDAT
  } ppa_p1_t;

  // byte address of a register index
  function automatic logic [7:0] ppa_byte_addr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction

endpackage

// file: design/ppa_ahb_regs.sv
// ahb-lite register slave for the pin allocation block
`timescale 1ns/1ps
module ppa_ahb_regs
  import ppa_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // register fields
  input  wire logic [7:0]  pin_status,
  output logic [7:0]       dir_reg,
  output logic [3:0]       cfg_reg,
  output logic [5:0]       rel_reg
);

  logic        take;
  logic [7:0]  addr_reg;
  logic [7:0]  addr_next;
  logic        wpend_reg;
  logic        wpend_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0]  dir_next;
  logic [3:0]  cfg_next;
  logic [5:0]  rel_next;
  logic        dir_wr_reg;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // address phase capture, read mux, data phase write
  always_comb begin
    take = hsel & hready & htrans[PPA_HTRANS_ACT] & (hsize == PPA_HSIZE_WORD);
    wpend_next = take & hwrite;
    addr_next  = take ? haddr[7:0] : addr_reg;
    rdata_next = rdata_reg;
    dir_next   = dir_reg;
    cfg_next   = cfg_reg;
    rel_next   = rel_reg;
    if (take && !hwrite) begin
      if (haddr[7:0] == ppa_byte_addr(PPA_IDX_DIR)) begin
        rdata_next = {24'h00_0000, dir_reg};
      end else if (haddr[7:0] == ppa_byte_addr(PPA_IDX_CFG)) begin
        rdata_next = {28'h000_0000, cfg_reg};
      end else if (haddr[7:0] == ppa_byte_addr(PPA_IDX_REL)) begin
        rdata_next = {26'h000_0000, rel_reg};
      end else if (haddr[7:0] == ppa_byte_addr(PPA_IDX_STAT)) begin
        rdata_next = {24'h00_0000, pin_status};
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
    if (wpend_reg) begin
      if (addr_reg == ppa_byte_addr(PPA_IDX_DIR)) begin
        dir_next = hwdata[7:0];
      end else if (addr_reg == ppa_byte_addr(PPA_IDX_CFG)) begin
        cfg_next = hwdata[3:0];
      end else if (addr_reg == ppa_byte_addr(PPA_IDX_REL)) begin
        rel_next = hwdata[5:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg   <= 8'h00;
      wpend_reg  <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      dir_reg    <= PPA_DIR_RESET;
      cfg_reg    <= PPA_CFG_RESET;
      rel_reg    <= PPA_REL_RESET;
      dir_wr_reg <= 1'b0;
    end else begin
      addr_reg   <= addr_next;
      wpend_reg  <= wpend_next;
      rdata_reg  <= rdata_next;
      dir_reg    <= dir_next;
      cfg_reg    <= cfg_next;
      rel_reg    <= rel_next;
      dir_wr_reg <= dir_wr_reg |
                    (wpend_reg && addr_reg == ppa_byte_addr(PPA_IDX_DIR));
    end
  end

  dir_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !dir_wr_reg |-> dir_reg == PPA_DIR_RESET)
    else $error("direction bits left reset value without a write");

endmodule

// file: design/ppa_mode_decode.sv
// bus mode decode into per-pin function selects
`timescale 1ns/1ps
module ppa_mode_decode
  import ppa_pkg::*;
(
  // configuration
  input  wire logic [3:0] cfg,
  input  wire logic [5:0] rel,
  // pin function selects
  output ppa_p1_t         p1_sel,
  output logic            d0_bus,
  output logic            p2_addr,
  output logic            p3_addr,
  output logic            p4_addr,
  output logic            ctl_bus,
  output logic            wrl_bus,
  output logic            wrh_bus,
  output logic            hold_bus,
  output logic            rdy_bus,
  output logic            clk_bus,
  output logic [7:0]      status
);

  logic bus_on;
  logic mux_on;
  logic w16_on;

  always_comb begin
    bus_on   = !cfg[PPA_CFG_SCHIP];
    mux_on   = cfg[PPA_CFG_MUX];
    w16_on   = cfg[PPA_CFG_W16];
    d0_bus   = bus_on;
    p2_addr  = bus_on & !mux_on;
    p3_addr  = bus_on & !mux_on;
    p4_addr  = bus_on & cfg[PPA_CFG_EXTA] & !rel[PPA_REL_UADDR];
    ctl_bus  = bus_on;
    wrl_bus  = bus_on & !rel[PPA_REL_WRL];
    wrh_bus  = bus_on & w16_on & !rel[PPA_REL_WRH];
    hold_bus = bus_on & !rel[PPA_REL_HOLD];
    rdy_bus  = bus_on & !rel[PPA_REL_RDY];
    clk_bus  = bus_on & !rel[PPA_REL_CLK];
    if (!bus_on) begin
      p1_sel = PPA_P1_PORT;
    end else if (mux_on) begin
      p1_sel = w16_on ? PPA_P1_ADDAT : PPA_P1_ADDR;
    end else begin
      p1_sel = w16_on ? PPA_P1_DATA : PPA_P1_PORT;
    end
    status = {hold_bus, wrh_bus, wrl_bus, p4_addr, p2_addr, p1_sel, d0_bus};
  end

endmodule

// file: design/ppa_pin_mux.sv
// port and external bus pin allocation, top level
`timescale 1ns/1ps
// What this block does
// - port 6 direction bit: 0 port, 1 analog
// - port 6 direction bits reset to all ones
// - shared pin function from mode and registers
// - low pins carry data or address/data
// - port 1: port, data, address or address/data
// - port 2 low address in non-multiplexed mode
// - port 3 high address in non-multiplexed mode
// - port 4 upper address when external address enabled
// - function selection releases control pins to port
// - single-chip mode makes all shared pins ports
module ppa_pin_mux
  import ppa_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // bus controller side
  input  wire logic [23:0] bus_addr,
  input  wire logic [15:0] bus_dout,
  input  wire logic        bus_dout_oe,
  output logic [15:0]      bus_din,
  input  wire logic        bus_ale,
  input  wire logic        bus_rd_n,
  input  wire logic        low_byte_write_strobe,
  input  wire logic        high_byte_write_strobe,
  input  wire logic        bus_hold_ack,
  output logic             bus_hold_request,
  output logic             bus_ready,
  input  wire logic        bus_clk,
  // port side, ports 0 to 5
  input  wire logic [7:0]  p0_out,
  input  wire logic [7:0]  p0_oe,
  output logic [7:0]       p0_in,
  input  wire logic [7:0]  p1_out,
  input  wire logic [7:0]  p1_oe,
  output logic [7:0]       p1_in,
  input  wire logic [7:0]  p2_out,
  input  wire logic [7:0]  p2_oe,
  output logic [7:0]       p2_in,
  input  wire logic [7:0]  p3_out,
  input  wire logic [7:0]  p3_oe,
  output logic [7:0]       p3_in,
  input  wire logic [7:0]  p4_out,
  input  wire logic [7:0]  p4_oe,
  output logic [7:0]       p4_in,
  input  wire logic [7:0]  p5_out,
  input  wire logic [7:0]  p5_oe,
  output logic [7:0]       p5_in,
  // port side, open-drain port 6
  input  wire logic [7:0]  p6_out,
  output logic [7:0]       p6_in,
  output logic [7:0]       analog_sel,
  // pads
  input  wire logic [7:0]  pad0_in,
  output logic [7:0]       pad0_out,
  output logic [7:0]       pad0_oe,
  input  wire logic [7:0]  pad1_in,
  output logic [7:0]       pad1_out,
  output logic [7:0]       pad1_oe,
  input  wire logic [7:0]  pad2_in,
  output logic [7:0]       pad2_out,
  output logic [7:0]       pad2_oe,
  input  wire logic [7:0]  pad3_in,
  output logic [7:0]       pad3_out,
  output logic [7:0]       pad3_oe,
  input  wire logic [7:0]  pad4_in,
  output logic [7:0]       pad4_out,
  output logic [7:0]       pad4_oe,
  input  wire logic [7:0]  pad5_in,
  output logic [7:0]       pad5_out,
  output logic [7:0]       pad5_oe,
  output logic             pad_rd_out,
  output logic             pad_rd_oe,
  input  wire logic [7:0]  pad6_in,
  output logic [7:0]       pad6_out,
  output logic [7:0]       pad6_oe
);

  logic [7:0] port6_pin_direction;
  logic [3:0] cfg;
  logic [5:0] rel;
  logic [7:0] status;
  ppa_p1_t    p1_sel;
  logic       d0_bus;
  logic       p2_addr;
  logic       p3_addr;
  logic       p4_addr;
  logic       ctl_bus;
  logic       wrl_bus;
  logic       wrh_bus;
  logic       hold_bus;
  logic       rdy_bus;
  logic       clk_bus;

  logic [7:0]  pad0_out_next, pad0_oe_next, pad1_out_next, pad1_oe_next;
  logic [7:0]  pad2_out_next, pad2_oe_next, pad3_out_next, pad3_oe_next;
  logic [7:0]  pad4_out_next, pad4_oe_next, pad5_out_next, pad5_oe_next;
  logic [7:0]  pad6_oe_next, p6_in_next;
  logic        pad_rd_out_next, pad_rd_oe_next;
  logic [15:0] bus_din_next;
  logic        hold_req_next, ready_next;

  ////////////////////////////////////////////////////////////////////////////
  // registers and mode decode
  ppa_ahb_regs u_regs (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (hsize),
    .hwdata     (hwdata),
    .hready     (hready),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .hrdata     (hrdata),
    .pin_status (status),
    .dir_reg    (port6_pin_direction),
    .cfg_reg    (cfg),
    .rel_reg    (rel)
  );

  ppa_mode_decode u_dec (
    .cfg      (cfg),
    .rel      (rel),
    .p1_sel   (p1_sel),
    .d0_bus   (d0_bus),
    .p2_addr  (p2_addr),
    .p3_addr  (p3_addr),
    .p4_addr  (p4_addr),
    .ctl_bus  (ctl_bus),
    .wrl_bus  (wrl_bus),
    .wrh_bus  (wrh_bus),
    .hold_bus (hold_bus),
    .rdy_bus  (rdy_bus),
    .clk_bus  (clk_bus),
    .status   (status)
  );

  assign analog_sel = port6_pin_direction;
  assign pad6_out   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // pin multiplexer, next values
  always_comb begin
    // low data pins, address first while ale is high in multiplexed mode
    pad0_out_next = p0_out;
    pad0_oe_next  = p0_oe;
    if (d0_bus && cfg[PPA_CFG_MUX] && bus_ale) begin
      pad0_out_next = bus_addr[7:0];
      pad0_oe_next  = 8'hff;
    end else if (d0_bus) begin
      pad0_out_next = bus_dout[7:0];
      pad0_oe_next  = {8{bus_dout_oe}};
    end
    // port 1
    case (p1_sel)
      PPA_P1_DATA: begin
        pad1_out_next = bus_dout[15:8];
        pad1_oe_next  = {8{bus_dout_oe}};
      end
      PPA_P1_ADDR: begin
        pad1_out_next = bus_addr[15:8];
        pad1_oe_next  = 8'hff;
      end
      PPA_P1_ADDAT: begin
        pad1_out_next = bus_ale ? bus_addr[15:8] : bus_dout[15:8];
        pad1_oe_next  = bus_ale ? 8'hff : {8{bus_dout_oe}};
      end
      default: begin
        pad1_out_next = p1_out;
        pad1_oe_next  = p1_oe;
      end
    endcase
    // ports 2 to 4, address outputs
    pad2_out_next = p2_addr ? bus_addr[7:0] : p2_out;
    pad2_oe_next  = p2_addr ? 8'hff : p2_oe;
    pad3_out_next = p3_addr ? bus_addr[15:8] : p3_out;
    pad3_oe_next  = p3_addr ? 8'hff : p3_oe;
    pad4_out_next = p4_addr ? bus_addr[23:16] : p4_out;
    pad4_oe_next  = p4_addr ? 8'hff : p4_oe;
    // port 5, control pins
    pad5_out_next = p5_out;
    pad5_oe_next  = p5_oe;
    if (ctl_bus) begin
      pad5_out_next[PPA_P5_ALE] = bus_ale;
      pad5_oe_next[PPA_P5_ALE]  = 1'b1;
    end
    if (wrl_bus) begin
      pad5_out_next[PPA_P5_WRL] = low_byte_write_strobe;
      pad5_oe_next[PPA_P5_WRL]  = 1'b1;
    end
    if (wrh_bus) begin
      pad5_out_next[PPA_P5_WRH] = high_byte_write_strobe;
      pad5_oe_next[PPA_P5_WRH]  = 1'b1;
    end
    if (hold_bus) begin
      pad5_out_next[PPA_P5_HRQ] = 1'b0;
      pad5_oe_next[PPA_P5_HRQ]  = 1'b0;
      pad5_out_next[PPA_P5_HAK] = bus_hold_ack;
      pad5_oe_next[PPA_P5_HAK]  = 1'b1;
    end
    if (rdy_bus) begin
      pad5_out_next[PPA_P5_RDY] = 1'b0;
      pad5_oe_next[PPA_P5_RDY]  = 1'b0;
    end
    if (clk_bus) begin
      pad5_out_next[PPA_P5_CLK] = bus_clk;
      pad5_oe_next[PPA_P5_CLK]  = 1'b1;
    end
    pad_rd_out_next = ctl_bus ? bus_rd_n : 1'b1;
    pad_rd_oe_next  = ctl_bus;
    // bus inputs
    bus_din_next[7:0]  = d0_bus ? pad0_in : 8'h00;
    bus_din_next[15:8] = (p1_sel == PPA_P1_DATA || p1_sel == PPA_P1_ADDAT)
                         ? pad1_in : 8'h00;
    hold_req_next = hold_bus & pad5_in[PPA_P5_HRQ];
    ready_next    = rdy_bus ? pad5_in[PPA_P5_RDY] : 1'b1;
    // port 6, open drain pulls low only in port mode
    pad6_oe_next = ~port6_pin_direction & ~p6_out;
    p6_in_next   = ~port6_pin_direction & pad6_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered pin and bus outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad0_out         <= 8'h00;
      pad0_oe          <= 8'h00;
      pad1_out         <= 8'h00;
      pad1_oe          <= 8'h00;
      pad2_out         <= 8'h00;
      pad2_oe          <= 8'h00;
      pad3_out         <= 8'h00;
      pad3_oe          <= 8'h00;
      pad4_out         <= 8'h00;
      pad4_oe          <= 8'h00;
      pad5_out         <= 8'h00;
      pad5_oe          <= 8'h00;
      pad_rd_out       <= 1'b1;
      pad_rd_oe        <= 1'b0;
      pad6_oe          <= 8'h00;
      p6_in            <= 8'h00;
      p0_in            <= 8'h00;
      p1_in            <= 8'h00;
      p2_in            <= 8'h00;
      p3_in            <= 8'h00;
      p4_in            <= 8'h00;
      p5_in            <= 8'h00;
      bus_din          <= 16'h0000;
      bus_hold_request <= 1'b0;
      bus_ready        <= 1'b1;
    end else begin
      pad0_out         <= pad0_out_next;
      pad0_oe          <= pad0_oe_next;
      pad1_out         <= pad1_out_next;
      pad1_oe          <= pad1_oe_next;
      pad2_out         <= pad2_out_next;
      pad2_oe          <= pad2_oe_next;
      pad3_out         <= pad3_out_next;
      pad3_oe          <= pad3_oe_next;
      pad4_out         <= pad4_out_next;
      pad4_oe          <= pad4_oe_next;
      pad5_out         <= pad5_out_next;
      pad5_oe          <= pad5_oe_next;
      pad_rd_out       <= pad_rd_out_next;
      pad_rd_oe        <= pad_rd_oe_next;
      pad6_oe          <= pad6_oe_next;
      p6_in            <= p6_in_next;
      p0_in            <= pad0_in;
      p1_in            <= pad1_in;
      p2_in            <= pad2_in;
      p3_in            <= pad3_in;
      p4_in            <= pad4_in;
      p5_in            <= pad5_in;
      bus_din          <= bus_din_next;
      bus_hold_request <= hold_req_next;
      bus_ready        <= ready_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  analog_no_drive_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    ($past(port6_pin_direction) & pad6_oe) == 8'h00)
    else $error("analog port 6 pin is driven");

  low_data_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    $past(d0_bus) && !$past(cfg[PPA_CFG_MUX])
    |-> pad0_out == $past(bus_dout[7:0]))
    else $error("low data pins do not follow bus data");

  p1_addr_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    $past(p1_sel) == PPA_P1_ADDR
    |-> pad1_out == $past(bus_addr[15:8]) && pad1_oe == 8'hff)
    else $error("port 1 pins do not carry high address");

  p2_addr_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    !$past(cfg[PPA_CFG_SCHIP]) && !$past(cfg[PPA_CFG_MUX])
    |-> pad2_out == $past(bus_addr[7:0]) && pad2_oe == 8'hff)
    else $error("port 2 pins do not carry low address");

  p4_port_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    $past(hresetn) && !$past(cfg[PPA_CFG_EXTA])
    |-> pad4_out == $past(p4_out) && pad4_oe == $past(p4_oe))
    else $error("port 4 pins not released with address control off");

  wrh_port_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    $past(hresetn) && !$past(cfg[PPA_CFG_W16])
    |-> pad5_oe[PPA_P5_WRH] == $past(p5_oe[PPA_P5_WRH]))
    else $error("upper write strobe driven on 8-bit bus");

  single_chip_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    $past(hresetn) && $past(cfg[PPA_CFG_SCHIP])
    |-> pad0_oe == $past(p0_oe) && pad1_oe == $past(p1_oe)
        && pad3_oe == $past(p3_oe) && pad5_out == $past(p5_out)
        && !pad_rd_oe)
    else $error("bus function left on in single-chip mode");

  ale_pin_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    !$past(cfg[PPA_CFG_SCHIP])
    |-> pad5_out[PPA_P5_ALE] == $past(bus_ale) && pad5_oe[PPA_P5_ALE])
    else $error("address latch enable pin not following bus");

endmodule

// file: dv/ppa_ext_dev.sv
// external bus device model on the shared pads
`timescale 1ns/1ps
module ppa_ext_dev (
  // clock
  input  wire logic        hclk,
  // pads driven by the block
  input  wire logic [7:0]  pad0_out,
  input  wire logic [7:0]  pad0_oe,
  input  wire logic [7:0]  pad1_out,
  input  wire logic [7:0]  pad1_oe,
  input  wire logic [7:0]  pad5_out,
  input  wire logic [7:0]  pad5_oe,
  input  wire logic        pad_rd_out,
  input  wire logic        pad_rd_oe,
  // device behaviour
  input  wire logic        hold_req,
  input  wire logic        ready,
  input  wire logic [15:0] rd_word,
  // resolved pad levels
  output logic [7:0]       pad0_in,
  output logic [7:0]       pad1_in,
  output logic [7:0]       pad5_in
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  float_reg = 8'h5a;
  logic [15:0] drv;
  logic [7:0]  drv5;
  // undriven lines wander every cycle
  always @(posedge hclk) begin
    float_reg <= ~float_reg;
  end
  ////////////////////////////////////////////////////////////////////////////
  // device drives read data only while the read strobe is low, hold and ready always
  always_comb begin
    drv = (pad_rd_oe & ~pad_rd_out) ? rd_word : {float_reg, float_reg};
    drv5 = {float_reg[7:4], hold_req, float_reg[2], ready, float_reg[0]};
    pad0_in = (pad0_oe & pad0_out) | (~pad0_oe & drv[7:0]);
    pad1_in = (pad1_oe & pad1_out) | (~pad1_oe & drv[15:8]);
    pad5_in = (pad5_oe & pad5_out) | (~pad5_oe & drv5);
  end
endmodule

// file: dv/tb_top.sv
// self-checking testbench for the pin allocation block
`timescale 1ns/1ps
module tb_top
  import ppa_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////
  logic            hclk = 1'b0;
  logic            hresetn = 1'b0;
  logic            hsel = 1'b0;
  logic            hwrite = 1'b0;
  logic [1:0]      htrans = 2'h0;
  logic [31:0]     haddr = 32'h0000_0000;
  logic [31:0]     hwdata = 32'h0000_0000;
  logic [23:0]     bus_addr = 24'hc3_a55a;
  logic [15:0]     bus_dout = 16'h9669;
  logic            bus_dout_oe = 1'b1;
  logic            bus_ale = 1'b1;
  logic            bus_rd_n = 1'b1;
  logic            strobe_lo = 1'b1;
  logic            strobe_hi = 1'b1;
  logic            hold_ack = 1'b1;
  logic            bus_clk = 1'b1;
  logic            dev_hold = 1'b1;
  logic            dev_rdy = 1'b0;
  logic [5:0][7:0] po = 48'h4244_3322_1100;
  logic [5:0][7:0] poe = 48'hffff_ffff_ffff;
  int              n_checks = 0;
  int              miscompares = 0;
  wire             hreadyout;
  wire             hresp_o;
  wire  [31:0]     hrdata;
  wire  [15:0]     bus_din;
  wire             hold_req_o;
  wire             ready_o;
  wire             pad_rd_out;
  wire             pad_rd_oe;
  wire  [7:0]      p6_in;
  wire  [7:0]      analog_sel;
  wire  [7:0]      pad6_oe;
  wire  [7:0]      pad6_in;
  wire  [5:0][7:0] pin;
  wire  [5:0][7:0] pdi;
  wire  [5:0][7:0] pdo;
  wire  [5:0][7:0] pdoe;

  always #20 hclk = ~hclk;
  // pull-up on the open-drain pins, plain pins read back their drive
  assign pad6_in = ~pad6_oe;
  assign pdi[4:2] = pdo[4:2];

  ////////////////////////////////////////////////////////////////////////////
  ppa_pin_mux ppa_pin_mux_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp_o),
    .hrdata(hrdata),
    .bus_addr(bus_addr), .bus_dout(bus_dout), .bus_dout_oe(bus_dout_oe),
    .bus_din(bus_din), .bus_ale(bus_ale), .bus_rd_n(bus_rd_n),
    .low_byte_write_strobe(strobe_lo), .high_byte_write_strobe(strobe_hi),
    .bus_hold_ack(hold_ack), .bus_hold_request(hold_req_o),
    .bus_ready(ready_o), .bus_clk(bus_clk),
    .p0_out(po[0]), .p0_oe(poe[0]), .p0_in(pin[0]),
    .p1_out(po[1]), .p1_oe(poe[1]), .p1_in(pin[1]),
    .p2_out(po[2]), .p2_oe(poe[2]), .p2_in(pin[2]),
    .p3_out(po[3]), .p3_oe(poe[3]), .p3_in(pin[3]),
    .p4_out(po[4]), .p4_oe(poe[4]), .p4_in(pin[4]),
    .p5_out(po[5]), .p5_oe(poe[5]), .p5_in(pin[5]),
    .p6_out(8'h0f), .p6_in(p6_in), .analog_sel(analog_sel),
    .pad0_in(pdi[0]), .pad0_out(pdo[0]), .pad0_oe(pdoe[0]),
    .pad1_in(pdi[1]), .pad1_out(pdo[1]), .pad1_oe(pdoe[1]),
    .pad2_in(pdi[2]), .pad2_out(pdo[2]), .pad2_oe(pdoe[2]),
    .pad3_in(pdi[3]), .pad3_out(pdo[3]), .pad3_oe(pdoe[3]),
    .pad4_in(pdi[4]), .pad4_out(pdo[4]), .pad4_oe(pdoe[4]),
    .pad5_in(pdi[5]), .pad5_out(pdo[5]), .pad5_oe(pdoe[5]),
    .pad_rd_out(pad_rd_out), .pad_rd_oe(pad_rd_oe),
    .pad6_in(pad6_in), .pad6_out(), .pad6_oe(pad6_oe)
  );

  ppa_ext_dev ppa_ext_dev_i (
    .hclk(hclk), .pad0_out(pdo[0]), .pad0_oe(pdoe[0]),
    .pad1_out(pdo[1]), .pad1_oe(pdoe[1]), .pad5_out(pdo[5]),
    .pad5_oe(pdoe[5]), .pad_rd_out(pad_rd_out), .pad_rd_oe(pad_rd_oe),
    .hold_req(dev_hold), .ready(dev_rdy), .rd_word(16'hbeef),
    .pad0_in(pdi[0]), .pad1_in(pdi[1]), .pad5_in(pdi[5])
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_ready;
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: ready %h expected %h", $time, hreadyout, 1'b1);
      wrap_up;
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_ready;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
  endtask

  task automatic settle;
    repeat (3) @(posedge hclk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    chk(32'(analog_sel), 32'h0000_00ff);
    ahb(1'b0, PPA_IDX_DIR, 32'h0000_0000, r);
    chk(r, 32'h0000_00ff);
    ahb(1'b0, PPA_IDX_CFG, 32'h0000_0000, r);
    chk(r, 32'h0000_0008);
    ahb(1'b0, 8'h20, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    chk(32'(pdo[2]), 32'(po[2]));
    chk(32'(pdo[4]), 32'(po[4]));
    chk(32'({pad_rd_oe, hold_req_o, ready_o}), 32'h0000_0001);
    chk(32'(pin[2]), 32'(po[2]));
    chk(32'(hresp_o), 32'h0000_0000);
    $display("test reset done");

    ahb(1'b1, PPA_IDX_DIR, 32'h0000_005a, r);
    settle;
    chk(32'(analog_sel), 32'h0000_005a);
    chk(32'(pad6_oe), 32'h0000_00a0);
    chk(32'(p6_in), 32'h0000_0005);
    ahb(1'b0, PPA_IDX_DIR, 32'h0000_0000, r);
    chk(r, 32'h0000_005a);
    $display("test direction done");

    for (int c = 0; c < 8; c++) begin
      ahb(1'b1, PPA_IDX_CFG, 32'(c), r);
      settle;
      chk(32'(pdo[0]), 32'(c[0] ? bus_addr[7:0] : bus_dout[7:0]));
      r = 32'(c[0] ? bus_addr[15:8] : c[1] ? bus_dout[15:8] : po[1]);
      chk(32'(pdo[1]), r);
      chk(32'(pdo[2]), 32'(c[0] ? po[2] : bus_addr[7:0]));
      chk(32'(pdo[3]), 32'(c[0] ? po[3] : bus_addr[15:8]));
      chk(32'(pdo[4]), 32'(c[2] ? bus_addr[23:16] : po[4]));
      chk(32'(pdo[5] & 8'h35), 32'(c[1] ? 8'h35 : 8'h25));
      chk(32'({hold_req_o, ready_o}), 32'h0000_0002);
    end
    $display("test bus modes done");

    ahb(1'b1, PPA_IDX_CFG, 32'h0000_0006, r);
    bus_dout_oe <= 1'b0;
    bus_rd_n <= 1'b0;
    bus_ale <= 1'b0;
    settle;
    chk(32'(bus_din), 32'h0000_beef);
    chk(32'(pdoe[1]), 32'h0000_0000);
    chk(32'(pin[1]), 32'h0000_00be);
    chk(32'({pad_rd_oe, pad_rd_out}), 32'h0000_0002);
    @(posedge hclk);
    bus_rd_n <= 1'b1;
    bus_dout_oe <= 1'b1;
    $display("test bus read done");

    ahb(1'b1, PPA_IDX_REL, 32'h0000_003f, r);
    settle;
    chk(32'(pdo[4]), 32'(po[4]));
    chk(32'(pdo[5] & 8'h35), 32'h0000_0000);
    chk(32'({hold_req_o, ready_o}), 32'h0000_0001);
    ahb(1'b0, PPA_IDX_REL, 32'h0000_0000, r);
    chk(r, 32'h0000_003f);
    ahb(1'b0, PPA_IDX_STAT, 32'h0000_0000, r);
    chk(r, 32'h0000_000b);
    $display("test release done");
    wrap_up;
  end
endmodule
